// ===== rtl/port_pkg.sv
/*
 * Shared constants and carriers for the port 6 / port 7 pin function block.
 * Assumes one 10 MHz clock and a plain single-cycle register port.
 */
package port_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int IO_W = 3;
  localparam int OS_W = 4;
  localparam int CMD_W = 2;

  // Register offsets on the plain register port
  localparam logic [ADDR_W-1:0] OFS_PORT6_DIRECTION = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PORT6_DATA = 8'h01;
  localparam logic [ADDR_W-1:0] OFS_PORT7_DIRECTION = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_PORT7_DATA = 8'h03;

  // Reset values and read answers
  localparam logic [DATA_W-1:0] RST_DIRECTION = 8'h00;
  localparam logic [DATA_W-1:0] RST_DATA = 8'h00;
  localparam logic [DATA_W-1:0] RD_WRITE_ONLY = 8'hFF;
  localparam logic [DATA_W-1:0] RD_UNMAPPED = 8'h00;
  localparam logic [DATA_W-1:0] RD_IDLE = 8'h00;

  // Port 7 has no pin at bits 7 and 3
  localparam logic [DATA_W-1:0] P7_IMPL_MASK = 8'h77;
  localparam logic [DATA_W-1:0] P6_IMPL_MASK = 8'hFF;

  // Port 7 pin positions
  localparam int P7_RXD_BIT = 1;
  localparam int P7_TXD_BIT = 2;
  localparam int P7_TV_RESET_BIT = 4;
  localparam int P7_TV_CLOCK_BIT = 5;
  localparam int P7_TV_OUT_BIT = 6;

  // Timer V output select value that leaves the pin to general I/O
  localparam logic [OS_W-1:0] TV_OS_GPIO = 4'h0;
  localparam logic [CMD_W-1:0] CMD_NORMAL = 2'h0;

  // Decode kind per port 6 pin: pin 0 is channel 0 A, pin 4 channel 1 A, the rest B/C/D
  typedef enum {KIND_CH0_A, KIND_CH1_A, KIND_BCD} tz_kind_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  typedef struct packed {
    logic [DATA_W-1:0] out_disable;        // Per port 6 pin
    logic [CMD_W-1:0] combination_mode;
    logic external_clock_stop;
    logic [DATA_W-1:0] pulse_mode;         // Per port 6 pin
    logic [DATA_W*IO_W-1:0] io_select;     // 3 bits per port 6 pin
  } tz_cfg_s;

endpackage : port_pkg

// ===== rtl/tz_pin_decode.sv
/*
 * Decides whether one timer Z pin is driven by the timer or left to GPIO.
 * Assumes the timer settings are stable register outputs of the timer.
 */
`timescale 1ns/100ps
module tz_pin_decode #(
  parameter port_pkg::tz_kind_e KIND = port_pkg::KIND_BCD
) (
  input wire logic out_disable,                 // Channel output off
  input wire logic [port_pkg::CMD_W-1:0] cmd,   // Combination mode
  input wire logic stop,                        // External clock stop
  input wire logic pwm,                         // Pulse mode bit
  input wire logic [port_pkg::IO_W-1:0] io,     // I/O select field
  output logic timer_drives                     // Pin is timer output
);

  // 001 or 01X selects compare output
  function automatic logic io_is_output(input logic [port_pkg::IO_W-1:0] f);
    io_is_output = (f[2] == 1'b0) && (f[1:0] != 2'b00);
  endfunction : io_is_output

  logic normal_out;

  always_comb begin
    normal_out = !out_disable && (cmd == port_pkg::CMD_NORMAL)
                 && io_is_output(io);
    case (KIND)
      port_pkg::KIND_CH0_A: begin
        timer_drives = normal_out && !stop;
      end
      port_pkg::KIND_CH1_A: begin
        timer_drives = normal_out;
      end
      port_pkg::KIND_BCD: begin
        // Unlisted settings fall back to GPIO, the safe choice for a pin
        timer_drives = (normal_out && !pwm)
                       || (!out_disable && pwm)
                       || (!out_disable && (cmd != port_pkg::CMD_NORMAL));
      end
      default: begin
        timer_drives = 1'b0;
      end
    endcase
  end

endmodule : tz_pin_decode

// ===== rtl/pin_mux_cell.sv
/*
 * Output driver stage and read value for one group of port pins.
 * Assumes pin inputs are synchronous to clk.
 */
`timescale 1ns/100ps
module pin_mux_cell #(
  parameter int W = 8,
  parameter logic [W-1:0] IMPL = '1
) (
  input wire logic clk,                 // System clock
  input wire logic rst,                 // Sync reset, high
  input wire logic ce,                  // Clock enable
  input wire logic [W-1:0] dir,         // 1 = output
  input wire logic [W-1:0] latch,       // Data latch
  input wire logic [W-1:0] periph_sel,  // Peripheral owns output
  input wire logic [W-1:0] periph_out,  // Peripheral output level
  input wire logic [W-1:0] force_in,    // Peripheral owns as input
  input wire logic [W-1:0] pin_in,      // Pin level
  output logic [W-1:0] pin_out,         // Pin output level
  output logic [W-1:0] pin_oe_n,        // Low while driving
  output logic [W-1:0] rd_val           // Value seen by a read
);

  logic [W-1:0] next_drive;
  logic [W-1:0] next_out;

  always_comb begin
    next_drive = (periph_sel | (dir & ~force_in)) & IMPL;
    next_out = ((periph_sel & periph_out) | (~periph_sel & latch)) & IMPL;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out <= '0;
      pin_oe_n <= '1;
    end else if (ce) begin
      pin_out <= next_out;
      pin_oe_n <= ~next_drive;
    end
  end

  // Latch for outputs, live pin for inputs
  assign rd_val = (dir & latch) | (~dir & pin_in);

endmodule : pin_mux_cell

// ===== rtl/io_port_pin_function_ctrl.sv
/*
 * Port 6 and port 7 direction/data registers and pin function selection
 * between GPIO, timer Z, timer V and the second serial channel.
 * Assumes peripheral settings arrive as stable levels from their blocks
 * and that pin inputs are already synchronous to clk.
 */
// Chosen here: the address map and the strobed register port.
`timescale 1ns/100ps

module io_port_pin_function_ctrl #(
  parameter int W = port_pkg::DATA_W
) (
  input wire logic clk,                          // 10 MHz system clock
  input wire logic rst,                          // Sync reset, high
  input wire logic ce,                           // Freezes all state low
  input wire port_pkg::bus_req_s bus,            // Register request
  output logic [W-1:0] rdata,                    // Read data, next cycle
  input wire logic [W-1:0] p6_pin_in,            // Port 6 pin levels
  output logic [W-1:0] p6_pin_out,               // Port 6 output levels
  output logic [W-1:0] p6_pin_oe_n,              // Port 6 drive, low
  input wire logic [W-1:0] p7_pin_in,            // Port 7 pin levels
  output logic [W-1:0] p7_pin_out,               // Port 7 output levels
  output logic [W-1:0] p7_pin_oe_n,              // Port 7 drive, low
  input wire port_pkg::tz_cfg_s tz_cfg,          // Timer Z pin settings
  input wire logic [W-1:0] tz_out,               // Timer Z pin outputs
  output logic [W-1:0] tz_capture,               // Timer Z capture inputs
  input wire logic [port_pkg::OS_W-1:0] timer_v_output_select, // 0 = GPIO
  input wire logic timer_v_out,                  // Timer V output level
  output logic timer_v_clock_in,                 // Timer V clock input
  output logic timer_v_reset_in,                 // Timer V reset input
  input wire logic txd_mode,                     // Pin 2 is transmit
  input wire logic tx_data,                      // Serial transmit level
  input wire logic rx_on,                        // Serial receive enable
  output logic rxd                               // Serial receive input
);

  logic [W-1:0] port6_direction;
  logic [W-1:0] port6_data;
  logic [W-1:0] port7_direction;
  logic [W-1:0] port7_data;
  logic [W-1:0] p6_sel;
  logic [W-1:0] p7_sel;
  logic [W-1:0] p7_force_in;
  logic [W-1:0] p7_periph;
  logic [W-1:0] p6_rd;
  logic [W-1:0] p7_rd;
  logic [W-1:0] next_rdata;

  function automatic logic hit(input port_pkg::bus_req_s b,
                               input logic [port_pkg::ADDR_W-1:0] ofs);
    hit = b.wr && (b.addr == ofs);
  endfunction : hit

  // 001 or 01X on port 6 pin n selects compare output
  function automatic logic tz_io_out(input port_pkg::tz_cfg_s c,
                                     input int n);
    logic [port_pkg::IO_W-1:0] f;
    f = c.io_select[n*port_pkg::IO_W +: port_pkg::IO_W];
    tz_io_out = !f[port_pkg::IO_W-1] && (f[1:0] != 2'b00);
  endfunction : tz_io_out

  // Register writes; direction is write-only
  always_ff @(posedge clk) begin
    if (rst) begin
      port6_direction <= port_pkg::RST_DIRECTION;
      port7_direction <= port_pkg::RST_DIRECTION;
    end else if (ce) begin
      if (hit(bus, port_pkg::OFS_PORT6_DIRECTION)) begin
        port6_direction <= bus.wdata & port_pkg::P6_IMPL_MASK;
      end
      if (hit(bus, port_pkg::OFS_PORT7_DIRECTION)) begin
        port7_direction <= bus.wdata & port_pkg::P7_IMPL_MASK;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port6_data <= port_pkg::RST_DATA;
      port7_data <= port_pkg::RST_DATA;
    end else if (ce) begin
      if (hit(bus, port_pkg::OFS_PORT6_DATA)) begin
        port6_data <= bus.wdata & port_pkg::P6_IMPL_MASK;
      end
      if (hit(bus, port_pkg::OFS_PORT7_DATA)) begin
        port7_data <= bus.wdata & port_pkg::P7_IMPL_MASK;
      end
    end
  end

  // Timer Z ownership of each port 6 pin
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_tz
      localparam port_pkg::tz_kind_e K =
        (g == 0) ? port_pkg::KIND_CH0_A :
        (g == 4) ? port_pkg::KIND_CH1_A : port_pkg::KIND_BCD;
      tz_pin_decode #(.KIND(K)) u_dec (
        .out_disable(tz_cfg.out_disable[g]),
        .cmd(tz_cfg.combination_mode),
        .stop(tz_cfg.external_clock_stop),
        .pwm(tz_cfg.pulse_mode[g]),
        .io(tz_cfg.io_select[g*port_pkg::IO_W +: port_pkg::IO_W]),
        .timer_drives(p6_sel[g])
      );
    end
  endgenerate

  // Peripheral ownership of port 7 pins
  always_comb begin
    p7_sel = '0;
    p7_force_in = '0;
    p7_periph = '0;
    p7_sel[port_pkg::P7_TV_OUT_BIT] =
      (timer_v_output_select != port_pkg::TV_OS_GPIO);
    p7_periph[port_pkg::P7_TV_OUT_BIT] = timer_v_out;
    p7_sel[port_pkg::P7_TXD_BIT] = txd_mode;
    p7_periph[port_pkg::P7_TXD_BIT] = tx_data;
    // Receive pin must not fight the far transmitter
    p7_force_in[port_pkg::P7_RXD_BIT] = rx_on;
  end

  pin_mux_cell #(.W(W), .IMPL(port_pkg::P6_IMPL_MASK)) u_p6 (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .dir(port6_direction),
    .latch(port6_data),
    .periph_sel(p6_sel),
    .periph_out(tz_out),
    .force_in('0),
    .pin_in(p6_pin_in),
    .pin_out(p6_pin_out),
    .pin_oe_n(p6_pin_oe_n),
    .rd_val(p6_rd)
  );

  pin_mux_cell #(.W(W), .IMPL(port_pkg::P7_IMPL_MASK)) u_p7 (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .dir(port7_direction),
    .latch(port7_data),
    .periph_sel(p7_sel),
    .periph_out(p7_periph),
    .force_in(p7_force_in),
    .pin_in(p7_pin_in),
    .pin_out(p7_pin_out),
    .pin_oe_n(p7_pin_oe_n),
    .rd_val(p7_rd)
  );

  // Peripheral inputs see the pin whatever the GPIO direction
  always_ff @(posedge clk) begin
    if (rst) begin
      tz_capture <= '0;
      timer_v_clock_in <= 1'b0;
      timer_v_reset_in <= 1'b0;
      rxd <= 1'b0;
    end else if (ce) begin
      tz_capture <= p6_pin_in;
      timer_v_clock_in <= p7_pin_in[port_pkg::P7_TV_CLOCK_BIT];
      timer_v_reset_in <= p7_pin_in[port_pkg::P7_TV_RESET_BIT];
      rxd <= p7_pin_in[port_pkg::P7_RXD_BIT];
    end
  end

  // Read mux; data stands one cycle only
  always_comb begin
    next_rdata = port_pkg::RD_IDLE;
    if (bus.rd) begin
      case (bus.addr)
        port_pkg::OFS_PORT6_DIRECTION: begin
          next_rdata = port_pkg::RD_WRITE_ONLY;
        end
        port_pkg::OFS_PORT7_DIRECTION: begin
          next_rdata = port_pkg::RD_WRITE_ONLY;
        end
        port_pkg::OFS_PORT6_DATA: begin
          next_rdata = p6_rd;
        end
        port_pkg::OFS_PORT7_DATA: begin
          next_rdata = (p7_rd & port_pkg::P7_IMPL_MASK)
                       | ~port_pkg::P7_IMPL_MASK;
        end
        default: begin
          next_rdata = port_pkg::RD_UNMAPPED;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= port_pkg::RD_IDLE;
    end else if (ce) begin
      rdata <= next_rdata;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_p7_dir_reset: assert property (
    $past(rst) |-> (port7_direction == port_pkg::RST_DIRECTION)
                   && (p7_pin_oe_n == '1))
    else $error("port 7 direction not cleared by reset");

  chk_p7_reserved_ones: assert property (
    $past(ce && bus.rd && bus.addr == port_pkg::OFS_PORT7_DATA)
      |-> rdata[7] && rdata[3])
    else $error("port 7 reserved data bits not read as one");

  chk_p7_dir_drive: assert property (
    $past(ce) |-> p7_pin_oe_n[0] == !$past(port7_direction[0]))
    else $error("port 7 pin 0 drive does not follow direction");

  chk_p7_latch_out: assert property (
    $past(ce && !txd_mode) |-> p7_pin_out[2] == $past(port7_data[2]))
    else $error("port 7 pin 2 output differs from latch");

  chk_p7_read_latch: assert property (
    $past(ce && bus.rd && bus.addr == port_pkg::OFS_PORT7_DATA
          && port7_direction[0]) |-> rdata[0] == $past(port7_data[0]))
    else $error("output pin read did not return latch");

  chk_p7_read_pin: assert property (
    $past(ce && bus.rd && bus.addr == port_pkg::OFS_PORT7_DATA
          && !port7_direction[5]) |-> rdata[5] == $past(p7_pin_in[5]))
    else $error("input pin read did not return pin level");

  chk_tv_out_override: assert property (
    $past(ce && timer_v_output_select != port_pkg::TV_OS_GPIO)
      |-> !p7_pin_oe_n[6] && p7_pin_out[6] == $past(timer_v_out))
    else $error("timer V output does not own pin 6");

  chk_tv_clock_feed: assert property (
    $past(ce && !rst) |-> timer_v_clock_in == $past(p7_pin_in[5])
                  && timer_v_reset_in == $past(p7_pin_in[4]))
    else $error("timer V inputs do not follow pins 5 and 4");

  chk_rx_input: assert property (
    $past(ce && !rst && rx_on)
      |-> p7_pin_oe_n[1] && rxd == $past(p7_pin_in[1]))
    else $error("receive pin driven or not fed to serial");

  chk_tz_pwm_out: assert property (
    $past(ce && !tz_cfg.out_disable[1] && tz_cfg.pulse_mode[1])
      |-> !p6_pin_oe_n[1] && p6_pin_out[1] == $past(tz_out[1]))
    else $error("pulse mode does not drive timer output");

  chk_tz_a0_gpio: assert property (
    $past(ce && tz_cfg.out_disable[0])
      |-> p6_pin_oe_n[0] == !$past(port6_direction[0]))
    else $error("disabled channel 0 A pin not under GPIO");

  chk_p7_dir_store: assert property (
    $past(ce && hit(bus, port_pkg::OFS_PORT7_DIRECTION))
      |-> port7_direction == ($past(bus.wdata) & port_pkg::P7_IMPL_MASK))
    else $error("port 7 direction write not stored per pin");

  chk_p7_dir_reserved: assert property (
    (port7_direction & ~port_pkg::P7_IMPL_MASK) == '0
      && (p7_pin_oe_n & ~port_pkg::P7_IMPL_MASK)
         == ~port_pkg::P7_IMPL_MASK)
    else $error("port 7 reserved bit position holds a direction");

  chk_tv_out_gpio: assert property (
    $past(ce && timer_v_output_select == port_pkg::TV_OS_GPIO)
      |-> p7_pin_oe_n[6] == !$past(port7_direction[6])
          && p7_pin_out[6] == $past(port7_data[6]))
    else $error("pin 6 not under GPIO with output select zero");

  chk_tv_reset_feed: assert property (
    $past(ce && !rst) |-> timer_v_reset_in == $past(p7_pin_in[4]))
    else $error("timer V reset input does not follow pin 4");

  chk_tx_pin_owner: assert property (
    $past(ce && txd_mode)
      |-> !p7_pin_oe_n[2] && p7_pin_out[2] == $past(tx_data))
    else $error("transmit mode does not own pin 2");

  chk_serial_first: assert property (
    $past(ce && rx_on && port7_direction[1]) |-> p7_pin_oe_n[1])
    else $error("GPIO output overrode receive pin");

  chk_tz_bcd_gpio: assert property (
    $past(ce && tz_cfg.out_disable[2])
      |-> p6_pin_oe_n[2] == !$past(port6_direction[2])
          && p6_pin_out[2] == $past(port6_data[2]))
    else $error("disabled channel 0 C pin not under GPIO");

  chk_tz_compare_out: assert property (
    $past(ce && !tz_cfg.out_disable[3] && !tz_cfg.pulse_mode[3]
          && tz_cfg.combination_mode == port_pkg::CMD_NORMAL
          && tz_io_out(tz_cfg, 3))
      |-> !p6_pin_oe_n[3] && p6_pin_out[3] == $past(tz_out[3]))
    else $error("compare select does not drive channel 0 D pin");

  chk_tz_comb_out: assert property (
    $past(ce && !tz_cfg.out_disable[5]
          && tz_cfg.combination_mode != port_pkg::CMD_NORMAL)
      |-> !p6_pin_oe_n[5] && p6_pin_out[5] == $past(tz_out[5]))
    else $error("combination mode does not drive channel 1 B pin");

  chk_tz_a1_out: assert property (
    $past(ce && !tz_cfg.out_disable[4] && tz_io_out(tz_cfg, 4)
          && tz_cfg.combination_mode == port_pkg::CMD_NORMAL)
      |-> !p6_pin_oe_n[4] && p6_pin_out[4] == $past(tz_out[4]))
    else $error("channel 1 A pin not driven by compare output");

  chk_tz_a0_stop: assert property (
    $past(ce && tz_cfg.external_clock_stop)
      |-> p6_pin_oe_n[0] == !$past(port6_direction[0]))
    else $error("stopped clock left timer driving channel 0 A");

  chk_p6_read_mix: assert property (
    $past(ce && bus.rd && bus.addr == port_pkg::OFS_PORT6_DATA)
      |-> rdata == $past(port6_direction & port6_data
                         | ~port6_direction & p6_pin_in))
    else $error("port 6 read mixes latch and pins wrongly");

  chk_p6_timer_first: assert property (
    $past(ce && p6_sel[6])
      |-> !p6_pin_oe_n[6] && p6_pin_out[6] == $past(tz_out[6]))
    else $error("GPIO latch overrode timer on port 6 pin 6");

  cov_p7_output: cover property (
    $past(ce && port7_direction[0]) && !p7_pin_oe_n[0]);
  cov_p7_read: cover property (
    $past(bus.rd && bus.addr == port_pkg::OFS_PORT7_DATA) && ce);
  cov_tz_combination: cover property (
    tz_cfg.combination_mode != port_pkg::CMD_NORMAL && !p6_pin_oe_n[2]);
  cov_serial: cover property (rx_on && txd_mode && !p7_pin_oe_n[2]);

endmodule : io_port_pin_function_ctrl

// ===== tb/pin_partner.sv
/*
 * Far side of one port: an outside driver that owns each pin the block
 * leaves undriven. Assumes the block's enables are low while it drives.
 */
`timescale 1ns/100ps
module pin_partner #(
  parameter int W = 8
) (
  input wire logic [W-1:0] pin_out,    // Block output levels
  input wire logic [W-1:0] pin_oe_n,   // Block drive enables, low
  input wire logic [W-1:0] ext_level,  // Outside driver levels
  output logic [W-1:0] pin_level       // Resolved pin levels
);
  // Outside driver backs off wherever the block drives
  assign pin_level = (~pin_oe_n & pin_out) | (pin_oe_n & ext_level);
endmodule : pin_partner

// ===== tb/testbench.sv
/*
 * Self-checking bench for the port 6 / port 7 pin function block.
 * Assumes the pin partner resolves every pin from both drivers.
 */
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  port_pkg::bus_req_s bus = '0;
  port_pkg::tz_cfg_s tz_cfg;
  port_pkg::tz_cfg_s c;
  logic [7:0] rdata, p6_out, p6_oe_n, p7_out, p7_oe_n, p6_pin, p7_pin;
  logic [7:0] p6_ext = 8'h00;
  logic [7:0] p7_ext = 8'h00;
  logic [7:0] tz_out = 8'h00;
  logic [7:0] tz_capture, d, l, e, drv, m;
  logic [3:0] tv_sel = 4'h0;
  logic tv_out = 1'b0;
  logic txd_mode = 1'b0;
  logic tx_data = 1'b0;
  logic rx_on = 1'b0;
  logic tv_clk, tv_rst, rxd;
  logic rd_seen = 1'b0;
  logic [7:0] exp_q[$];
  int mismatches = 0;
  int comparisons = 0;

  always #50 clk = ~clk;

  io_port_pin_function_ctrl i_io_port_pin_function_ctrl (
    .clk(clk), .rst(rst), .ce(ce), .bus(bus), .rdata(rdata),
    .p6_pin_in(p6_pin), .p6_pin_out(p6_out), .p6_pin_oe_n(p6_oe_n),
    .p7_pin_in(p7_pin), .p7_pin_out(p7_out), .p7_pin_oe_n(p7_oe_n),
    .tz_cfg(tz_cfg), .tz_out(tz_out), .tz_capture(tz_capture),
    .timer_v_output_select(tv_sel), .timer_v_out(tv_out),
    .timer_v_clock_in(tv_clk), .timer_v_reset_in(tv_rst),
    .txd_mode(txd_mode), .tx_data(tx_data), .rx_on(rx_on), .rxd(rxd));
  pin_partner i_pin_partner_p6 (.pin_out(p6_out), .pin_oe_n(p6_oe_n),
    .ext_level(p6_ext), .pin_level(p6_pin));
  pin_partner i_pin_partner_p7 (.pin_out(p7_out), .pin_oe_n(p7_oe_n),
    .ext_level(p7_ext), .pin_level(p7_pin));

  task automatic stop_test();
    if (mismatches == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
  endtask : rd

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  function automatic logic tz_drv(input int i);
    logic [2:0] io;
    logic cmp;
    io = tz_cfg.io_select[3*i +: 3];
    cmp = !tz_cfg.out_disable[i] && (io == 3'h1 || io[2:1] == 2'h1);
    if (i == 0) begin
      return cmp && tz_cfg.combination_mode == 2'h0
             && !tz_cfg.external_clock_stop;
    end
    if (i == 4) begin
      return cmp && tz_cfg.combination_mode == 2'h0;
    end
    return cmp || (!tz_cfg.out_disable[i]
           && (tz_cfg.combination_mode != 2'h0 || tz_cfg.pulse_mode[i]));
  endfunction : tz_drv

  // Read answers land one cycle after the strobe
  always @(posedge clk) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("mismatch at %0t: read answer not expected", $time);
      end else begin
        chk(rdata, exp_q.pop_front(), "read data");
      end
    end
    rd_seen <= bus.rd & ce;
  end

  initial begin
    #1000000;
    mismatches++;
    stop_test();
  end

  initial begin
    tz_cfg = '0;
    tz_cfg.out_disable = 8'hFF;
    void'($urandom(32'h8EB6FA0B));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    settle();
    chk(p7_oe_n, 8'hFF, "p7 drive after reset");
    chk(p6_oe_n, 8'hFF, "p6 drive after reset");
    rd(port_pkg::OFS_PORT7_DATA, 8'h88);
    rd(port_pkg::OFS_PORT7_DIRECTION, port_pkg::RD_WRITE_ONLY);
    rd(8'h40, port_pkg::RD_UNMAPPED);
    for (int n = 0; n < 20; n++) begin
      d = 8'($urandom);
      l = 8'($urandom);
      p7_ext <= 8'($urandom);
      p6_ext <= 8'($urandom);
      wr(port_pkg::OFS_PORT7_DIRECTION, d);
      wr(port_pkg::OFS_PORT7_DATA, l);
      wr(port_pkg::OFS_PORT6_DIRECTION, d);
      wr(port_pkg::OFS_PORT6_DATA, ~l);
      settle();
      e = d & l | ~d & p7_ext;
      chk(p7_oe_n, ~d | 8'h88, "p7 drive");
      chk(p7_out & d & 8'h77, l & d & 8'h77, "p7 level");
      chk(p6_oe_n, ~d, "p6 drive");
      chk({6'h0, tv_clk, tv_rst}, {6'h0, e[5], e[4]}, "tv in");
      rd(port_pkg::OFS_PORT7_DATA, e & 8'h77 | 8'h88);
      rd(port_pkg::OFS_PORT6_DATA, d & ~l | ~d & p6_ext);
    end
    wr(port_pkg::OFS_PORT7_DIRECTION, 8'h02);
    wr(port_pkg::OFS_PORT7_DATA, 8'h02);
    for (int n = 0; n < 16; n++) begin
      tv_sel <= 4'(n);
      tv_out <= 1'($urandom);
      tx_data <= 1'($urandom);
      txd_mode <= n[0];
      rx_on <= n[1];
      settle();
      e = {1'b1, n == 0, 3'h7, !n[0], n[1], 1'b1};
      chk(p7_oe_n, e, "p7 function");
      chk(p7_out & ~e, {1'b0, tv_out, 3'h0, tx_data, 2'h2} & ~e,
          "p7 function level");
      chk({7'h0, rxd}, {7'h0, n[1] ? p7_ext[1] : 1'b1}, "rx in");
    end
    for (int n = 0; n < 60; n++) begin
      c = $bits(c)'({$urandom, $urandom});
      if (n[0]) begin
        c.combination_mode = 2'h0;
      end
      if (n[1]) begin
        c.external_clock_stop = 1'b0;
      end
      tz_cfg <= c;
      tz_out <= 8'($urandom);
      d = 8'($urandom);
      l = 8'($urandom);
      wr(port_pkg::OFS_PORT6_DIRECTION, d);
      wr(port_pkg::OFS_PORT6_DATA, l);
      settle();
      for (int i = 0; i < 8; i++) begin
        drv[i] = tz_drv(i);
      end
      m = drv | d;
      chk(p6_oe_n, ~m, "p6 function");
      chk(p6_out & m, (drv & tz_out | ~drv & l) & m, "p6 level");
      chk(tz_capture, p6_pin, "capture");
    end
    // Frozen clock enable must swallow the write
    ce <= 1'b0;
    wr(port_pkg::OFS_PORT7_DATA, 8'h55);
    ce <= 1'b1;
    // Timer V and transmit still own pins 6 and 2; reads follow direction
    e = {1'b1, tv_out, 2'h0, 1'b1, tx_data, 2'h2} | p7_ext & 8'h31;
    rd(port_pkg::OFS_PORT7_DATA, e);
    repeat (3) @(posedge clk);
    if (exp_q.size() != 0) begin
      mismatches++;
      $display("mismatch at %0t: read answers missing", $time);
    end
    stop_test();
  end
endmodule : testbench
